// >>> hw/tsd_regs.vh
// Purpose: register map, field positions and reset values of the timer sync/DMA block
// Assumes: byte address of a register is four times its index
// Notes: definitions only
//
// Operation
// - Event slave mode trigger sets counter run
// - Select 001 drives run state on trigger out
// - Source 010 takes partner timer trigger input
// - Source 100 takes channel 0 input edge
// - Sync bit aligns own start with slaves
// - Channel 0 edge starts chained counters together
// - Enabled internal event raises DMA request
// - Buffer access redirected to base index register
// - Length plus one requests, stepping one word each
// - Length zero gives one request; events restart
// - Debug halt with freeze bit stops counter
// - Divider field sets sample clock 1/2/4
// - Bit 7 enables auto-reload shadow copy
// - Align mode 00 counts edge-aligned by direction
// - Center modes 01 and 10 gate compare flag by direction
// - Direction gating applies to output-mode channels
`ifndef TSD_REGS_VH
`define TSD_REGS_VH
// ****************************************
// Register indices
// ****************************************
`define TSD_IX_CTL0 5'h00
`define TSD_IX_SYNC 5'h01
`define TSD_IX_DCFG 5'h02
`define TSD_IX_DBUF 5'h03
`define TSD_IX_STAT 5'h04
`define TSD_IX_MASK 5'h05
`define TSD_IX_DMEN 5'h06
`define TSD_IX_CNT 5'h07
`define TSD_IX_ARR 5'h08
`define TSD_IX_CMP 5'h09
`define TSD_IX_CHMS 5'h0A
// ****************************************
// Fields
// ****************************************
`define TSD_RUN 0
`define TSD_DIR 4
`define TSD_SHADOW 7
`define TSD_SMODE_EVENT 3'h6
`define TSD_SMODE_OFF 3'h0
`define TSD_SRC_CH0 3'h4
`define TSD_MMC_RUN 3'h1
`define TSD_MMC_UPD 3'h2
`define TSD_MS_OUTPUT 2'h0
`define TSD_EV_TRIG 0
`define TSD_EV_CMP 1
`define TSD_EV_UPD 2
// ****************************************
// Reset values and responses
// ****************************************
`define TSD_CTL0_RST 10'h000
`define TSD_ARR_RST 16'hFFFF
`define TSD_RESP_OK 2'h0
`define TSD_RESP_ERR 2'h2
`endif

// >>> hw/tsd_timer_sync_dma.v
// Purpose: timer start synchronisation, DMA burst access and control register 0
// Assumes: trigger inputs from partner timers run on MCLK; CH0_IN and DBG_HALT do not
// Notes: one write and one read under way at a time on the register bus
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tsd_regs.vh"

module tsd_timer_sync_dma (
  // Clock and reset
  input wire MCLK,
  input wire SRST,
  // AXI4-Lite write
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Trigger link
  input wire [3:0] INTERNAL_TRIGGER_INPUT,
  input wire CH0_IN,
  output reg TRIGGER_OUTPUT,
  // DMA, debug, sample tick, interrupt
  output reg DMA_REQ,
  input wire DBG_HALT,
  output reg SAMPLE_TICK,
  output reg IRQ
);

  // ****************************************
  // State
  // ****************************************
  reg [9:0] ctl0_reg;
  reg [12:0] sync_reg;
  reg [12:0] dcfg_reg;
  reg [2:0] stat_reg;
  reg [2:0] mask_reg;
  reg [2:0] dmen_reg;
  reg [15:0] cnt_reg;
  reg [15:0] arr_reg;
  reg [15:0] arr_sh_reg;
  reg [15:0] cmp_reg;
  reg [1:0] chms_reg;
  reg start_pend_reg;
  reg [1:0] div_reg;
  reg ch0_s1_reg, ch0_s2_reg, ch0_prev_reg;
  reg halt_s1_reg, halt_s2_reg;
  reg [3:0] iti_prev_reg;
  reg busy_reg;
  reg [4:0] bidx_reg;
  reg aw_hold_reg, w_hold_reg;
  reg [4:0] aw_ix_reg;
  reg aw_bad_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  // ****************************************
  // Register decode
  // ****************************************
  // Buffer index maps to base plus burst step; 5-bit wrap is harmless
  function [4:0] eff_ix;
    input [4:0] ix;
    begin
      if (ix == `TSD_IX_DBUF)
        eff_ix = dcfg_reg[4:0] + bidx_reg;
      else
        eff_ix = ix;
    end
  endfunction
  function mapped;
    input [4:0] ix;
    begin
      mapped = (ix <= `TSD_IX_CHMS) && (ix != `TSD_IX_DBUF);
    end
  endfunction
  function [31:0] reg_rd;
    input [4:0] ix;
    begin
      case (ix)
        `TSD_IX_CTL0: reg_rd = {22'h0, ctl0_reg};
        `TSD_IX_SYNC: reg_rd = {19'h0, sync_reg};
        `TSD_IX_DCFG: reg_rd = {19'h0, dcfg_reg};
        `TSD_IX_STAT: reg_rd = {29'h0, stat_reg};
        `TSD_IX_MASK: reg_rd = {29'h0, mask_reg};
        `TSD_IX_DMEN: reg_rd = {29'h0, dmen_reg};
        `TSD_IX_CNT: reg_rd = {16'h0000, cnt_reg};
        `TSD_IX_ARR: reg_rd = {16'h0000, arr_reg};
        `TSD_IX_CMP: reg_rd = {16'h0000, cmp_reg};
        `TSD_IX_CHMS: reg_rd = {30'h0, chms_reg};
        default: reg_rd = 32'h00000000;
      endcase
    end
  endfunction

  // ****************************************
  // Bus handshakes
  // ****************************************
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_go = aw_hold_reg & w_hold_reg & ~S_AXI_BVALID;
  wire rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
  wire aw_hold_next = (aw_hold_reg | aw_take) & ~wr_go;
  wire w_hold_next = (w_hold_reg | w_take) & ~wr_go;
  wire rvalid_next = rd_go | (S_AXI_RVALID & ~S_AXI_RREADY);
  wire [4:0] ar_ix = S_AXI_ARADDR[6:2];
  wire ar_bad = S_AXI_ARADDR[7];
  wire [4:0] wr_ix = eff_ix(aw_ix_reg);
  wire [4:0] rd_ix = eff_ix(ar_ix);
  wire wr_ok = wr_go & ~aw_bad_reg & mapped(wr_ix);
  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] wval = (reg_rd(wr_ix) & ~wmask) | (w_data_reg & wmask);
  // Completed buffer access advances the burst
  wire buf_done = (wr_go & (aw_ix_reg == `TSD_IX_DBUF) & ~aw_bad_reg)
                | (rd_go & (ar_ix == `TSD_IX_DBUF) & ~ar_bad);

  // ****************************************
  // Trigger selection
  // ****************************************
  reg sel_edge;
  always @* begin
    case (sync_reg[6:4])
      3'h0, 3'h1, 3'h2, 3'h3: sel_edge = INTERNAL_TRIGGER_INPUT[sync_reg[5:4]] &
                                         ~iti_prev_reg[sync_reg[5:4]];
      `TSD_SRC_CH0: sel_edge = ch0_s2_reg & ~ch0_prev_reg;
      default: sel_edge = 1'b0;
    endcase
  end
  wire trig_ev = sel_edge & (sync_reg[2:0] != `TSD_SMODE_OFF);
  wire ev_start = trig_ev & (sync_reg[2:0] == `TSD_SMODE_EVENT);
  // With sync bit set our own start waits one cycle, the latency a slave
  // needs to see the trigger output edge, so both count from one edge
  wire start_now = ev_start & ~sync_reg[7];
  wire start_late = ev_start & sync_reg[7];

  // ****************************************
  // Counter
  // ****************************************
  wire freeze = halt_s2_reg & sync_reg[12];
  wire cnt_en = ctl0_reg[`TSD_RUN] & ~freeze;
  wire center = ctl0_reg[6:5] != 2'h0;
  wire [15:0] arr_eff = ctl0_reg[`TSD_SHADOW] ? arr_sh_reg : arr_reg;
  reg [15:0] cnt_next;
  reg dir_next;
  reg upd;
  always @* begin
    cnt_next = cnt_reg;
    dir_next = ctl0_reg[`TSD_DIR];
    upd = 1'b0;
    if (cnt_en) begin
      if (!ctl0_reg[`TSD_DIR]) begin
        if (cnt_reg >= arr_eff) begin
          upd = 1'b1;
          if (center) begin
            dir_next = 1'b1;
            cnt_next = cnt_reg - 16'h0001;
          end else begin
            cnt_next = 16'h0000;
          end
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end else begin
        if (cnt_reg == 16'h0000) begin
          upd = 1'b1;
          if (center) begin
            dir_next = 1'b0;
            cnt_next = 16'h0001;
          end else begin
            cnt_next = arr_eff;
          end
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
    end
  end

  // Compare flag gated by count direction in center modes 01 and 10
  reg dir_ok;
  always @* begin
    case (ctl0_reg[6:5])
      2'h1: dir_ok = ctl0_reg[`TSD_DIR];
      2'h2: dir_ok = ~ctl0_reg[`TSD_DIR];
      default: dir_ok = 1'b1;
    endcase
  end
  wire out_mode = chms_reg == `TSD_MS_OUTPUT;
  wire cmp_hit = cnt_en & (cnt_reg == cmp_reg) & out_mode & dir_ok;
  wire [2:0] ev_set = {upd, cmp_hit, trig_ev};
  wire dma_ev = |(ev_set & dmen_reg);

  // Sample clock divider; reserved code 11 falls back to no division
  reg [1:0] div_lim;
  always @* begin
    case (ctl0_reg[9:8])
      2'h1: div_lim = 2'h1;
      2'h2: div_lim = 2'h3;
      default: div_lim = 2'h0;
    endcase
  end

  // ****************************************
  // Sequential logic
  // ****************************************
  always @(posedge MCLK) begin
    if (SRST) begin
      ctl0_reg <= `TSD_CTL0_RST;
      sync_reg <= 13'h0000;
      dcfg_reg <= 13'h0000;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      dmen_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      arr_reg <= `TSD_ARR_RST;
      arr_sh_reg <= `TSD_ARR_RST;
      cmp_reg <= 16'h0000;
      chms_reg <= 2'h0;
      start_pend_reg <= 1'b0;
      div_reg <= 2'h0;
      ch0_s1_reg <= 1'b0;
      ch0_s2_reg <= 1'b0;
      ch0_prev_reg <= 1'b0;
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
      iti_prev_reg <= 4'h0;
      busy_reg <= 1'b0;
      bidx_reg <= 5'h00;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_ix_reg <= 5'h00;
      aw_bad_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `TSD_RESP_OK;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `TSD_RESP_OK;
      TRIGGER_OUTPUT <= 1'b0;
      DMA_REQ <= 1'b0;
      SAMPLE_TICK <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // Pin inputs pass two flops before any logic looks at them
      ch0_s1_reg <= CH0_IN;
      ch0_s2_reg <= ch0_s1_reg;
      ch0_prev_reg <= ch0_s2_reg;
      halt_s1_reg <= DBG_HALT;
      halt_s2_reg <= halt_s1_reg;
      iti_prev_reg <= INTERNAL_TRIGGER_INPUT;

      // Write channel capture, either order
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      S_AXI_AWREADY <= ~aw_hold_next;
      S_AXI_WREADY <= ~w_hold_next;
      if (aw_take) begin
        aw_ix_reg <= S_AXI_AWADDR[6:2];
        aw_bad_reg <= S_AXI_AWADDR[7];
      end
      if (w_take) begin
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `TSD_RESP_OK : `TSD_RESP_ERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end

      // Read channel
      S_AXI_RVALID <= rvalid_next;
      S_AXI_ARREADY <= ~rvalid_next;
      if (rd_go) begin
        if (!ar_bad && mapped(rd_ix)) begin
          S_AXI_RDATA <= reg_rd(rd_ix);
          S_AXI_RRESP <= `TSD_RESP_OK;
        end else begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `TSD_RESP_ERR;
        end
      end

      // Counter moves first so that a software write this cycle wins, except the DIR bit in center modes
      cnt_reg <= cnt_next;
      ctl0_reg[`TSD_DIR] <= dir_next;
      if (upd)
        arr_sh_reg <= arr_reg;
      if (wr_ok) begin
        case (wr_ix)
          `TSD_IX_CTL0: begin
            if (center)
              ctl0_reg <= {wval[9:5], dir_next, wval[3:0]};
            else
              ctl0_reg <= wval[9:0];
          end
          `TSD_IX_SYNC: sync_reg <= wval[12:0];
          `TSD_IX_DCFG: dcfg_reg <= wval[12:0];
          `TSD_IX_MASK: mask_reg <= wval[2:0];
          `TSD_IX_DMEN: dmen_reg <= wval[2:0];
          `TSD_IX_CNT: cnt_reg <= wval[15:0];
          `TSD_IX_ARR: arr_reg <= wval[15:0];
          `TSD_IX_CMP: cmp_reg <= wval[15:0];
          `TSD_IX_CHMS: chms_reg <= wval[1:0];
          default: ;
        endcase
      end
      // Hardware start beats a software clear in the same cycle
      start_pend_reg <= start_late;
      if (start_now || start_pend_reg)
        ctl0_reg[`TSD_RUN] <= 1'b1;
      // Sticky status, set wins over write-one-to-clear
      if (wr_ok && wr_ix == `TSD_IX_STAT)
        stat_reg <= (stat_reg & ~wval[2:0]) | ev_set;
      else
        stat_reg <= stat_reg | ev_set;
      IRQ <= |((stat_reg | ev_set) & mask_reg);
      // Trigger output; run state counts a pending start as running
      case (sync_reg[10:8])
        `TSD_MMC_RUN: TRIGGER_OUTPUT <= ctl0_reg[`TSD_RUN] | start_now | start_late
                             | start_pend_reg;
        `TSD_MMC_UPD: TRIGGER_OUTPUT <= upd;
        default: TRIGGER_OUTPUT <= 1'b0;
      endcase

      // DMA burst: request drops for one cycle between steps
      if (dma_ev) begin
        busy_reg <= 1'b1;
        bidx_reg <= 5'h00;
        DMA_REQ <= 1'b1;
      end else if (buf_done && busy_reg) begin
        DMA_REQ <= 1'b0;
        if (bidx_reg == dcfg_reg[12:8])
          busy_reg <= 1'b0;
        else
          bidx_reg <= bidx_reg + 5'h01;
      end else begin
        DMA_REQ <= busy_reg;
      end

      // Sample clock tick
      if (div_reg >= div_lim) begin
        div_reg <= 2'h0;
        SAMPLE_TICK <= 1'b1;
      end else begin
        div_reg <= div_reg + 2'h1;
        SAMPLE_TICK <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/tsd_checker.sv
// Purpose: port checker for the timer sync and DMA block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/10ps
// ****************************************
// Checker
// ****************************************
module tsd_checker (
  // Clock and reset
  input wire MCLK,
  input wire SRST,
  // Bus handshakes
  input wire S_AXI_AWREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Block outputs
  input wire DMA_REQ,
  input wire IRQ,
  input wire TRIGGER_OUTPUT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read data dropped early");
  AST_R_AFTER_AR: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  AST_RESET_IDLE: assert property (disable iff (1'b0) SRST |=> !DMA_REQ && !IRQ && !TRIGGER_OUTPUT)
    else $error("outputs active after reset");
  // A request may only end once an access has completed
  AST_REQ_DROP: assert property ($fell(DMA_REQ) |-> S_AXI_BVALID || S_AXI_RVALID)
    else $error("request withdrawn without access");
  AST_IRQ_CLEAR: assert property ($fell(IRQ) |-> $past(S_AXI_BVALID))
    else $error("interrupt cleared without write");
  AST_READY_BACK: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID && S_AXI_AWREADY) else $error("write path not reopened");
endmodule
bind tsd_timer_sync_dma tsd_checker chk (
  .MCLK(MCLK), .SRST(SRST), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .DMA_REQ(DMA_REQ), .IRQ(IRQ), .TRIGGER_OUTPUT(TRIGGER_OUTPUT)
);

// >>> tb/tsd_peer_timer.sv
// Purpose: partner timer, master towards the block and slave behind it
// Assumes: same clock as the block
// Notes: software run bit stands in as its trigger output
`timescale 1ns/10ps
// ****************************************
// Partner timer
// ****************************************
module tsd_peer_timer (
  input wire clk,
  input wire rst,
  input wire sw_start,
  input wire trg_in,
  output wire trg_out,
  output reg run
);
  reg trg_q;
  // Software start drives the link directly; run is set only by a trigger input edge
  assign trg_out = sw_start;
  always @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
      trg_q <= 1'b0;
    end else begin
      trg_q <= trg_in;
      if (trg_in && !trg_q) begin
        run <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/tsd_timer_sync_dma_ctl_bench.sv
// Purpose: self-checking bench for the timer sync and DMA block
// Assumes: 40 MHz clock, reset held three cycles
// Notes: all waits bounded
`timescale 1ns/10ps
// ****************************************
// Bench
// ****************************************
module tsd_timer_sync_dma_ctl_bench;
  reg mclk = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ch0 = 0, halt = 0, ps = 0;
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg [31:0] wd = 32'h0, d, e;
  reg [1:0] r;
  wire awr, wr_rdy, bv, arr, rv, trigger_output, req, tick, irq, ptrg, prun;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer miscompares = 0, n_checks = 0, i, k;
  tsd_timer_sync_dma dut (.MCLK(mclk), .SRST(srst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .INTERNAL_TRIGGER_INPUT({1'b0, ptrg, 2'b00}),
    .CH0_IN(ch0), .TRIGGER_OUTPUT(trigger_output), .DMA_REQ(req), .DBG_HALT(halt), .SAMPLE_TICK(tick), .IRQ(irq));
  tsd_peer_timer peer (.clk(mclk), .rst(srst), .sw_start(ps), .trg_in(trigger_output), .trg_out(ptrg),
    .run(prun));
  initial forever #12.5 mclk = ~mclk;
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] x, input [31:0] y);
    begin
      n_checks = n_checks + 1;
      if (y !== x) begin
        $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task tmo(input integer n);
    if (n >= 60) begin
      chk("wait", 0, 1);
      tally_and_finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge mclk);
      awa <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      for (i = 0; i < 60; i = i + 1) begin
        @(posedge mclk);
        if (awr) awv <= 0;
        if (wr_rdy) wv <= 0;
        if (bv === 1'b1) begin
          r = bresp;
          bre <= 0;
          i = 99;
        end
      end
      tmo((i == 60) ? 60 : 0);
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk);
      ara <= a;
      arv <= 1;
      rre <= 1;
      for (i = 0; i < 60; i = i + 1) begin
        @(posedge mclk);
        if (arr) arv <= 0;
        if (rv === 1'b1) begin
          d = rdata;
          r = rresp;
          rre <= 0;
          i = 99;
        end
      end
      tmo((i == 60) ? 60 : 0);
    end
  endtask
  task t_regs;
    begin
      rd(8'h00);
      chk("ctl0 reset", 32'h0, d);
      rd(8'h20);
      chk("reload reset", 32'hFFFF, d);
      chk("read resp", 32'h0, {30'h0, r});
      rd(8'h80);
      chk("unmapped resp", 32'h2, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      wr(8'h80, 32'h5);
      chk("unmapped write resp", 32'h2, {30'h0, r});
      wr(8'h00, 32'h80);
      chk("write resp", 32'h0, {30'h0, r});
      rd(8'h00);
      chk("shadow bit", 32'h80, d);
      $display("test regs done");
    end
  endtask
  task t_tick;
    begin
      // Code 3 is reserved and runs undivided
      for (k = 0; k < 4; k = k + 1) begin
        wr(8'h00, k << 8);
        repeat (4) @(posedge mclk);
        e = 0;
        repeat (8) @(posedge mclk) if (tick === 1'b1) e = e + 1;
        chk("sample ticks", (k == 3) ? 32'd8 : 32'd8 >> k, e);
      end
      $display("test tick done");
    end
  endtask
  task t_sync;
    begin
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h1);
      wr(8'h04, 32'h1C6);
      ch0 <= 1;
      for (k = 0; k < 60 && trigger_output !== 1'b1; k = k + 1) @(posedge mclk);
      tmo(k);
      repeat (2) @(posedge mclk);
      chk("peer started", 1, prun);
      chk("trigger out", 1, trigger_output);
      rd(8'h00);
      chk("run bit", 1, d[0]);
      rd(8'h10);
      chk("trigger flag", 1, d[0]);
      chk("irq", 1, irq);
      wr(8'h10, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq clear", 0, irq);
      ch0 <= 0;
      wr(8'h04, 32'h11C6);
      halt <= 1;
      repeat (4) @(posedge mclk);
      rd(8'h1C);
      e = d;
      repeat (5) @(posedge mclk);
      rd(8'h1C);
      chk("frozen count", e, d);
      halt <= 0;
      $display("test sync done");
    end
  endtask
  task t_dma;
    begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h26);
      ps <= 1;
      repeat (8) @(posedge mclk);
      rd(8'h00);
      chk("linked start", 1, d[0]);
      wr(8'h18, 32'h1);
      for (k = 0; k < 2; k = k + 1) begin
        wr(8'h08, 32'h8 | (k << 8));
        ps <= 0;
        @(posedge mclk);
        ps <= 1;
        for (e = 0; e <= k; e = e + 1) begin
          for (i = 0; i < 60 && req !== 1'b1; i = i + 1) @(posedge mclk);
          tmo(i);
          repeat (3) @(posedge mclk);
          chk("request held", 1, req);
          wr(8'h0C, 32'h100 + e + 16 * k);
        end
        repeat (4) @(posedge mclk);
        chk("no extra request", 0, req);
        rd(8'h20);
        chk("buffer to base", 32'h100 + 16 * k, d);
        rd(8'h24);
        if (k == 1) chk("buffer step", 32'h111, d);
      end
      $display("test dma done");
    end
  endtask
  // Stop, zero the count, clear status, then run with the given control word
  task cmp_run(input [31:0] ctl, input [31:0] ms, input integer n);
    begin
      wr(8'h00, 32'h0);
      wr(8'h1C, 32'h0);
      wr(8'h28, ms);
      wr(8'h10, 32'h7);
      wr(8'h00, ctl);
      repeat (n) @(posedge mclk);
      rd(8'h10);
    end
  endtask
  // Reload 16 and compare 5: early read sees only the first pass of the count
  task t_cmp;
    begin
      wr(8'h20, 32'h10);
      wr(8'h24, 32'h5);
      cmp_run(32'h1, 32'h0, 6);
      chk("edge up compare", 1, d[1]);
      cmp_run(32'h11, 32'h0, 6);
      chk("edge down early", 0, d[1]);
      repeat (30) @(posedge mclk);
      rd(8'h10);
      chk("edge down compare", 1, d[1]);
      cmp_run(32'h21, 32'h0, 6);
      chk("down-only on up pass", 0, d[1]);
      repeat (30) @(posedge mclk);
      rd(8'h10);
      chk("down-only on down pass", 1, d[1]);
      cmp_run(32'h41, 32'h0, 6);
      chk("up-only on up pass", 1, d[1]);
      cmp_run(32'h61, 32'h1, 40);
      chk("input mode no flag", 0, d[1]);
      $display("test compare done");
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 0;
    repeat (2) @(posedge mclk);
    t_regs;
    t_tick;
    t_sync;
    t_dma;
    t_cmp;
    tally_and_finish;
  end
endmodule
